// ==== wfpd_consts.svh ====
// Offsets, field positions, reset values and counts of the wake frame pattern detector.
// Assumes it is included by bare name wherever these values are needed.
// How it works
// - Per-filter 8-bit offset, zero is destination start.
// - Stored 16-bit CRC compared with computed CRC.
// - Pattern mode halts normal frame reception.
// - Detected pattern frame sets received status bit.
// - Notify by interrupt or power event, configurable.
// - Clearing the enable restores normal reception; in light sleep reception stays stopped.
// - Check frames for own or broadcast address.
// - Multicast frames also accepted with sixteen copies.
// - Six FF bytes then sixteen address copies.
// - Detection in full power and light sleep.
// - Light sleep enables pattern and filter detection.
// - Mask bit j feeds byte offset plus j.
// - Address-type bit picks multicast or unicast frames.
// - Disabled filter never reports a match.
`ifndef WFPD_CONSTS_SVH
`define WFPD_CONSTS_SVH
`define WFPD_OFS_WCSR 8'h00
`define WFPD_OFS_MASK 8'h04
`define WFPD_FILT_FIRST 4'h1
`define WFPD_FILT_LAST 4'h4
`define WFPD_SUB_BMASK 2'h0
`define WFPD_SUB_CMD 2'h1
`define WFPD_SUB_OFFSET 2'h2
`define WFPD_SUB_CRC 2'h3
`define WFPD_BIT_PAT_EN 0
`define WFPD_BIT_FILT_EN 1
`define WFPD_BIT_PAT_RCVD 2
`define WFPD_BIT_FRM_RCVD 3
`define WFPD_BIT_NOTIFY_PWR 4
`define WFPD_WCSR_RW_MASK 32'h0000_0013
`define WFPD_STS_MASK 32'h0000_000C
`define WFPD_CMD_BIT_EN 0
`define WFPD_CMD_BIT_MCAST 3
`define WFPD_BMASK_RW 32'h7FFF_FFFF
`define WFPD_CRC_POLY 16'h8005
`define WFPD_CRC_PRESET 16'h0000
`define WFPD_MASK_BITS 11'h01F
`define WFPD_ADDR_END 11'h00C
`define WFPD_DA_BYTES 11'h006
`define WFPD_SYNC_LEN 3'h6
`define WFPD_LAST_ADDR_BYTE 3'h5
`define WFPD_LAST_COPY 4'hF
`define WFPD_SYNC_BYTE 8'hFF
`define WFPD_POS_MAX 11'h7FF
`endif

// ==== wfpd_pkg.sv ====
// Types shared by the wake frame pattern detector.
// Assumes nothing beyond a SystemVerilog compiler.
package wfpd_pkg;
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic fcs_ok;
    logic [7:0] data;
  } wfpd_rx_beat_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } wfpd_avmm_req_t;

  typedef struct packed {
    logic [30:0] byte_mask;
    logic addr_mcast;
    logic enable;
    logic [7:0] offset;
    logic [15:0] crc;
  } wfpd_filter_t;

  typedef enum logic [2:0] {
    WFPD_SYNC = 3'h1,
    WFPD_MATCH = 3'h2,
    WFPD_FOUND = 3'h4
  } wfpd_pat_state_t;
endpackage : wfpd_pkg

// ==== wfpd_top.sv ====
// Wake frame pattern detector: pattern search, four CRC wake filters, Avalon-MM registers.
// Assumes a received byte stream on clk with frame marks and the frame check result on the last byte.
//
// Chosen here: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "wfpd_consts.svh"
module wfpd_top (
  // Clock and reset.
  input wire logic clk,
  input wire logic arst_n,
  // Receive byte stream and station state.
  input wire wfpd_pkg::wfpd_rx_beat_t rx_beat,
  input wire logic [47:0] station_addr,
  input wire logic light_sleep_state,
  // Avalon-MM slave.
  input wire wfpd_pkg::wfpd_avmm_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Notification and receive control.
  output logic irq,
  output logic power_event_output,
  output logic rx_normal_enable
);
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [31:0] wcsr_q;
  logic [31:0] mask_q;
  logic irq_q;
  logic pme_q;
  logic rx_norm_q;
  logic [10:0] pos_q;
  logic [10:0] cur_pos;
  logic [47:0] dst_q;
  wfpd_pkg::wfpd_filter_t filt_q [4];
  logic [15:0] crc_q [4];
  logic [15:0] crc_d [4];
  logic [3:0] filt_hit;
  wfpd_pkg::wfpd_pat_state_t pat_q;
  wfpd_pkg::wfpd_pat_state_t pat_d;
  logic [2:0] ff_cnt_q;
  logic [2:0] ff_cnt_d;
  logic [2:0] abyte_q;
  logic [2:0] abyte_d;
  logic [3:0] copy_q;
  logic [3:0] copy_d;
  logic pat_active;
  logic filt_active;
  logic frame_end;
  logic da_bcast;
  logic da_mcast;
  logic da_own;
  logic pat_hit;
  logic frm_hit;
  logic bus_write;
  logic [4:0] wsel;

  // Selector code: bit 4 valid, 0 status, 1 mask, 8+2*i for filter i; the sub-register is not encoded.
  function automatic logic [4:0] addr_sel(input logic [7:0] a);
    if (a == `WFPD_OFS_WCSR)
      addr_sel = 5'h10;
    else if (a == `WFPD_OFS_MASK)
      addr_sel = 5'h11;
    else if (a[7:4] >= `WFPD_FILT_FIRST && a[7:4] <= `WFPD_FILT_LAST && a[1:0] == 2'h0)
      addr_sel = {3'h7, 2'(a[5:4] - 2'h1)} == 5'h00 ? 5'h00 : {1'b1, 1'b1, 2'(a[7:4] - 4'h1), 1'b0} | {3'h0, 2'h0};
    else
      addr_sel = 5'h00;
  endfunction : addr_sel

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    for (int b = 0; b < 4; b++)
    begin
      old[8*b +: 8] = be[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    be_merge = old;
  endfunction : be_merge

  // Bit-serial CRC, most significant bit of each byte first.
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    for (int k = 7; k >= 0; k--)
    begin
      c = (c[15] ^ d[k]) ? ((c << 1) ^ `WFPD_CRC_POLY) : (c << 1);
    end
    crc16_byte = c;
  endfunction : crc16_byte

  // The selector function is decoded once per use; filter index and sub-register come from raw address bits.
  assign wsel = addr_sel(avs_req.address);
  assign bus_write = avs_req.write & ~waitreq_q;

  // One wait cycle on every access keeps read data registered.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      waitreq_q <= 1'b1;
    else
      waitreq_q <= ~((avs_req.read | avs_req.write) & waitreq_q);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_q <= 32'h0000_0000;
    else if (avs_req.read & waitreq_q)
    begin
      if (wsel == 5'h10)
        rdata_q <= wcsr_q;
      else if (wsel == 5'h11)
        rdata_q <= mask_q;
      else if (wsel[4])
      begin
        if (avs_req.address[3:2] == `WFPD_SUB_BMASK)
          rdata_q <= {1'b0, filt_q[avs_req.address[5:4] - 2'h1].byte_mask};
        else if (avs_req.address[3:2] == `WFPD_SUB_CMD)
          rdata_q <= {28'h0000000, filt_q[avs_req.address[5:4] - 2'h1].addr_mcast, 2'h0,
                      filt_q[avs_req.address[5:4] - 2'h1].enable};
        else if (avs_req.address[3:2] == `WFPD_SUB_OFFSET)
          rdata_q <= {24'h000000, filt_q[avs_req.address[5:4] - 2'h1].offset};
        else
          rdata_q <= {16'h0000, filt_q[avs_req.address[5:4] - 2'h1].crc};
      end
      else
        rdata_q <= 32'h0000_0000;
    end
  end

  // Filter configuration registers; mask bit 31 is held at zero.
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_filt_reg
      logic sel_me;
      logic [31:0] wv;
      assign sel_me = bus_write && wsel[4] && wsel[3] && (avs_req.address[5:4] - 2'h1) == 2'(i);
      always_comb
      begin
        wv = 32'h0000_0000;
        if (avs_req.address[3:2] == `WFPD_SUB_BMASK)
          wv = be_merge({1'b0, filt_q[i].byte_mask}, avs_req.writedata, avs_req.byteenable) & `WFPD_BMASK_RW;
        else if (avs_req.address[3:2] == `WFPD_SUB_CMD)
          wv = be_merge({28'h0000000, filt_q[i].addr_mcast, 2'h0, filt_q[i].enable}, avs_req.writedata,
                        avs_req.byteenable);
        else if (avs_req.address[3:2] == `WFPD_SUB_OFFSET)
          wv = be_merge({24'h000000, filt_q[i].offset}, avs_req.writedata, avs_req.byteenable);
        else
          wv = be_merge({16'h0000, filt_q[i].crc}, avs_req.writedata, avs_req.byteenable);
      end
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          filt_q[i] <= '0;
        else if (sel_me)
        begin
          if (avs_req.address[3:2] == `WFPD_SUB_BMASK)
            filt_q[i].byte_mask <= wv[30:0];
          else if (avs_req.address[3:2] == `WFPD_SUB_CMD)
          begin
            filt_q[i].enable <= wv[`WFPD_CMD_BIT_EN];
            filt_q[i].addr_mcast <= wv[`WFPD_CMD_BIT_MCAST];
          end
          else if (avs_req.address[3:2] == `WFPD_SUB_OFFSET)
            filt_q[i].offset <= wv[7:0];
          else
            filt_q[i].crc <= wv[15:0];
        end
      end
    end
  endgenerate

  // Position restarts with each frame.
  assign cur_pos = rx_beat.sof ? 11'h000 : pos_q;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      pos_q <= 11'h000;
    else if (rx_beat.valid && cur_pos != `WFPD_POS_MAX)
      pos_q <= 11'(cur_pos + 11'h001);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      dst_q <= 48'h0000_0000_0000;
    else if (rx_beat.valid && cur_pos < `WFPD_DA_BYTES)
      dst_q[8*cur_pos[2:0] +: 8] <= rx_beat.data;
  end

  assign pat_active = wcsr_q[`WFPD_BIT_PAT_EN] | light_sleep_state;
  assign filt_active = wcsr_q[`WFPD_BIT_FILT_EN] | light_sleep_state;
  assign frame_end = rx_beat.valid & rx_beat.eof & rx_beat.fcs_ok;
  assign da_bcast = &dst_q;
  assign da_mcast = dst_q[0] & ~da_bcast;
  assign da_own = dst_q == station_addr;

  // CRC over masked bytes, preset at frame start.
  generate
    for (genvar i = 0; i < 4; i++)
    begin : g_filt_crc
      logic [10:0] rel;
      logic take;
      logic [15:0] base;
      assign rel = 11'(cur_pos - {3'h0, filt_q[i].offset});
      assign take = cur_pos >= {3'h0, filt_q[i].offset} && rel < `WFPD_MASK_BITS && filt_q[i].byte_mask[rel[4:0]];
      assign base = rx_beat.sof ? `WFPD_CRC_PRESET : crc_q[i];
      assign crc_d[i] = take ? crc16_byte(base, rx_beat.data) : base;
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          crc_q[i] <= `WFPD_CRC_PRESET;
        else if (rx_beat.valid)
          crc_q[i] <= crc_d[i];
      end
      assign filt_hit[i] = filt_q[i].enable && (filt_q[i].addr_mcast ? dst_q[0] : ~dst_q[0]) &&
                           crc_d[i] == filt_q[i].crc;
    end
  endgenerate

  // Search for six sync bytes then sixteen station address copies past the address fields.
  always_comb
  begin
    pat_d = pat_q;
    ff_cnt_d = ff_cnt_q;
    abyte_d = abyte_q;
    copy_d = copy_q;
    if (rx_beat.sof)
    begin
      pat_d = wfpd_pkg::WFPD_SYNC;
      ff_cnt_d = 3'h0;
    end
    else if (rx_beat.valid && pat_active && cur_pos >= `WFPD_ADDR_END)
    begin
      case (pat_q)
        wfpd_pkg::WFPD_SYNC:
        begin
          if (ff_cnt_q == `WFPD_SYNC_LEN && rx_beat.data == station_addr[7:0])
          begin
            pat_d = wfpd_pkg::WFPD_MATCH;
            abyte_d = 3'h1;
            copy_d = 4'h0;
          end
          else if (rx_beat.data == `WFPD_SYNC_BYTE)
            ff_cnt_d = (ff_cnt_q == `WFPD_SYNC_LEN) ? ff_cnt_q : 3'(ff_cnt_q + 3'h1);
          else
            ff_cnt_d = 3'h0;
        end
        wfpd_pkg::WFPD_MATCH:
        begin
          if (rx_beat.data == station_addr[8*abyte_q +: 8])
          begin
            abyte_d = (abyte_q == `WFPD_LAST_ADDR_BYTE) ? 3'h0 : 3'(abyte_q + 3'h1);
            if (abyte_q == `WFPD_LAST_ADDR_BYTE)
            begin
              copy_d = 4'(copy_q + 4'h1);
              // The sixteenth copy completes while the count still reads fifteen.
              if (copy_q == `WFPD_LAST_COPY)
                pat_d = wfpd_pkg::WFPD_FOUND;
            end
          end
          else
          begin
            // A broken run may itself start a new sync stream.
            pat_d = wfpd_pkg::WFPD_SYNC;
            ff_cnt_d = (rx_beat.data == `WFPD_SYNC_BYTE) ? 3'h1 : 3'h0;
          end
        end
        wfpd_pkg::WFPD_FOUND:
          pat_d = wfpd_pkg::WFPD_FOUND;
        default:
          pat_d = wfpd_pkg::WFPD_SYNC;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pat_q <= wfpd_pkg::WFPD_SYNC;
      ff_cnt_q <= 3'h0;
      abyte_q <= 3'h0;
      copy_q <= 4'h0;
    end
    else
    begin
      pat_q <= pat_d;
      ff_cnt_q <= ff_cnt_d;
      abyte_q <= abyte_d;
      copy_q <= copy_d;
    end
  end

  assign pat_hit = frame_end && pat_active && pat_d == wfpd_pkg::WFPD_FOUND &&
                   (da_own | da_bcast | da_mcast);
  assign frm_hit = frame_end && filt_active && |filt_hit;

  // Status bits: hardware set wins over a write-one clear in the same cycle.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      wcsr_q <= 32'h0000_0000;
    else
    begin
      if (bus_write && wsel == 5'h10)
        wcsr_q <= (be_merge(wcsr_q, avs_req.writedata, avs_req.byteenable) & `WFPD_WCSR_RW_MASK) |
                  (wcsr_q & `WFPD_STS_MASK & ~(avs_req.writedata & {{8{avs_req.byteenable[3]}},
                  {8{avs_req.byteenable[2]}}, {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}}));
      if (pat_hit)
        wcsr_q[`WFPD_BIT_PAT_RCVD] <= 1'b1;
      if (frm_hit)
        wcsr_q[`WFPD_BIT_FRM_RCVD] <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      mask_q <= 32'h0000_0000;
    else if (bus_write && wsel == 5'h11)
      mask_q <= be_merge(mask_q, avs_req.writedata, avs_req.byteenable) & `WFPD_STS_MASK;
  end

  // Notification steered by the select bit; power event used when bit 4 is set, interrupt when it is clear.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_q <= 1'b0;
      pme_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(wcsr_q & mask_q) & ~wcsr_q[`WFPD_BIT_NOTIFY_PWR];
      pme_q <= |(wcsr_q & mask_q) & wcsr_q[`WFPD_BIT_NOTIFY_PWR];
    end
  end

  // Normal reception stops while pattern search runs.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rx_norm_q <= 1'b1;
    else
      rx_norm_q <= ~pat_active;
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = waitreq_q;
  assign irq = irq_q;
  assign power_event_output = pme_q;
  assign rx_normal_enable = rx_norm_q;

  property p_wait_one;
    @(posedge clk) disable iff (!arst_n)
    (avs_req.read | avs_req.write) && waitreq_q |=> !waitreq_q ##1 waitreq_q;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest not low for exactly one cycle");

  property p_pat_status;
    @(posedge clk) disable iff (!arst_n) pat_hit |=> wcsr_q[`WFPD_BIT_PAT_RCVD];
  endproperty
  a_pat_status: assert property (p_pat_status) else $error("pattern status not set");

  property p_bad_fcs;
    @(posedge clk) disable iff (!arst_n)
    !wcsr_q[`WFPD_BIT_PAT_RCVD] && !(rx_beat.valid && rx_beat.eof && rx_beat.fcs_ok) |=> !wcsr_q[`WFPD_BIT_PAT_RCVD];
  endproperty
  a_bad_fcs: assert property (p_bad_fcs) else $error("pattern status set without good frame");

  property p_irq_route;
    @(posedge clk) disable iff (!arst_n)
    |(wcsr_q & mask_q) |=> (irq_q != pme_q) && (pme_q == $past(wcsr_q[`WFPD_BIT_NOTIFY_PWR]));
  endproperty
  a_irq_route: assert property (p_irq_route) else $error("notification routed wrongly");

  property p_norm_off;
    @(posedge clk) disable iff (!arst_n) wcsr_q[`WFPD_BIT_PAT_EN] |=> !rx_norm_q;
  endproperty
  a_norm_off: assert property (p_norm_off) else $error("normal reception not stopped");

  property p_norm_back;
    @(posedge clk) disable iff (!arst_n)
    $fell(wcsr_q[`WFPD_BIT_PAT_EN]) && !light_sleep_state |=> rx_norm_q;
  endproperty
  a_norm_back: assert property (p_norm_back) else $error("normal reception not restored");

  property p_sleep_auto;
    @(posedge clk) disable iff (!arst_n) light_sleep_state |-> pat_active && filt_active;
  endproperty
  a_sleep_auto: assert property (p_sleep_auto) else $error("light sleep did not enable detection");

  property p_sof_restart;
    @(posedge clk) disable iff (!arst_n) rx_beat.sof |=> pat_q == wfpd_pkg::WFPD_SYNC && ff_cnt_q == 3'h0;
  endproperty
  a_sof_restart: assert property (p_sof_restart) else $error("search not restarted at frame start");

  property p_filt_disabled;
    @(posedge clk) disable iff (!arst_n) frm_hit |-> |(filt_hit & {filt_q[3].enable, filt_q[2].enable,
                                                   filt_q[1].enable, filt_q[0].enable});
  endproperty
  a_filt_disabled: assert property (p_filt_disabled) else $error("disabled filter matched");
endmodule : wfpd_top

// ==== wfpd_frame_src.sv ====
// Remote station model that plays frames into the detector, one byte a beat.
// Assumes the bench calls send from a process that runs on clk.
`timescale 1ns/1ns
module wfpd_frame_src (
  // Clock.
  input wire logic clk,
  // Byte stream towards the detector.
  output wfpd_pkg::wfpd_rx_beat_t rx_beat
);
  initial rx_beat = '0;
  // Idle beats carry inverted data, so a stale byte can never pass for a fresh one.
  task automatic idle();
    @(posedge clk);
    rx_beat <= '{1'b0, 1'b0, 1'b0, 1'b0, ~rx_beat.data};
  endtask : idle
  task automatic send(input logic [7:0] f[$], input logic good, input logic [31:0] gaps);
    for (int i = 0; i < f.size(); i++)
    begin
      if (gaps[i % 32])
        idle();
      @(posedge clk);
      rx_beat <= '{1'b1, i == 0, i == f.size() - 1, good && i == f.size() - 1, f[i]};
    end
    idle();
  endtask : send
endmodule : wfpd_frame_src

// ==== wfpd_tb_top.sv ====
// Self-checking bench of the wake frame pattern detector against a behavioural model.
// Assumes the design files and the frame source model are compiled before it.
`timescale 1ns/1ns
module wfpd_tb_top;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic light_sleep_state = 1'b0;
  logic [47:0] station_addr = 48'h0;
  wfpd_pkg::wfpd_rx_beat_t rx_beat;
  wfpd_pkg::wfpd_avmm_req_t avs_req = '0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, irq, power_event_output, rx_normal_enable;
  logic [31:0] lfsr = 32'h0001_4242;
  logic [31:0] fm [4] = '{32'h7FFF_FFFF, 32'h0000_0009, 32'h0000_00FF, 32'h0000_FFFF};
  logic [7:0] frm[$];
  logic [7:0] f_off [4];
  logic [30:0] f_mask [4];
  logic [3:0] f_cmd [4];
  logic [15:0] f_crc [4];
  int error_cnt = 0;
  int checked = 0;

  always #2 clk = ~clk;

  wfpd_top u_wfpd_top (.clk(clk), .arst_n(arst_n), .rx_beat(rx_beat), .station_addr(station_addr),
    .light_sleep_state(light_sleep_state), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .power_event_output(power_event_output),
    .rx_normal_enable(rx_normal_enable));
  wfpd_frame_src u_wfpd_frame_src (.clk(clk), .rx_beat(rx_beat));

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], ^(lfsr & 32'h8020_0003)};
    return lfsr;
  endfunction : rnd

  function automatic logic [15:0] crc_of(input int i);
    logic [15:0] c;
    c = 16'h0000;
    for (int j = 0; j < 31; j++)
      if (f_mask[i][j])
        for (int b = 7; b >= 0; b--)
          c = {c[14:0], 1'b0} ^ ((c[15] ^ frm[f_off[i] + j][b]) ? 16'h8005 : 16'h0000);
    return c;
  endfunction : crc_of

  // Returns the wake frame hit in bit 1 and the pattern hit in bit 0.
  function automatic logic [1:0] model(input logic [4:0] ctrl, input logic good);
    logic pat, flt;
    logic [47:0] da;
    pat = 1'b0;
    flt = 1'b0;
    da = {frm[5], frm[4], frm[3], frm[2], frm[1], frm[0]};
    if ((ctrl[0] || light_sleep_state) && (da == station_addr || da[0]))
      for (int p = 12; p + 102 <= frm.size(); p++)
      begin
        int n;
        n = 0;
        for (int k = 0; k < 102; k++)
          if (frm[p + k] === (k < 6 ? 8'hFF : station_addr[8 * ((k - 6) % 6) +: 8]))
            n++;
        if (n == 102)
          pat = 1'b1;
      end
    for (int i = 0; i < 4; i++)
      if ((ctrl[1] || light_sleep_state) && f_cmd[i][0] && f_cmd[i][3] == frm[0][0])
        if (crc_of(i) == f_crc[i])
          flt = 1'b1;
    return {flt & good, pat & good};
  endfunction : model

  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  // The master never counts wait states; only the watchdog ends a hung access.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_req <= '{~w, w, a, 4'hF, wd};
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_req <= '0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(n, e, x);
  endtask : rd_chk

  task automatic prog(input int i);
    wr(8'((i + 1) * 16), {1'b0, f_mask[i]});
    wr(8'((i + 1) * 16 + 4), {28'h0, f_cmd[i]});
    wr(8'((i + 1) * 16 + 8), {24'h0, f_off[i]});
    wr(8'((i + 1) * 16 + 12), {16'h0, f_crc[i]});
  endtask : prog

  task automatic build(input logic [47:0] da, input int copies);
    frm.delete();
    for (int k = 0; k < 6; k++)
      frm.push_back(da[8 * k +: 8]);
    repeat (8 + rnd() % 8) frm.push_back(8'(rnd()));
    if (copies > 0)
    begin
      repeat (6) frm.push_back(8'hFF);
      repeat (copies) for (int k = 0; k < 6; k++) frm.push_back(station_addr[8 * k +: 8]);
    end
    repeat (4) frm.push_back(8'(rnd()));
    while (frm.size() < 64)
      frm.push_back(8'(rnd()));
  endtask : build

  task automatic run(input string n, input logic [4:0] ctrl, input logic ls, input logic good, input logic [3:0] msk);
    logic [1:0] hit;
    wr(8'h04, {28'h0, msk});
    wr(8'h00, {27'h0, ctrl});
    light_sleep_state <= ls;
    repeat (2) @(posedge clk);
    chk({n, " normal rx"}, {31'h0, ~(ctrl[0] | ls)}, {31'h0, rx_normal_enable});
    hit = model(ctrl, good);
    u_wfpd_frame_src.send(frm, good, rnd());
    repeat (4) @(posedge clk);
    rd_chk({n, " status"}, 8'h00, {27'h0, ctrl[4], hit, ctrl[1:0]});
    chk({n, " irq"}, {31'h0, |(hit & msk[3:2]) & ~ctrl[4]}, {31'h0, irq});
    chk({n, " event"}, {31'h0, |(hit & msk[3:2]) & ctrl[4]}, {31'h0, power_event_output});
    wr(8'h00, {27'h0, ctrl} | 32'h0000_000C);
    repeat (2) @(posedge clk);
    chk({n, " cleared"}, 32'h0, {30'h0, irq, power_event_output});
    $display("test %s done", n);
  endtask : run

  initial
  begin
    logic [31:0] r;
    r = rnd();
    station_addr <= {r[15:0], rnd()} & 48'hFFFF_FFFF_FFFE;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    chk("reset outputs", 32'h9, {28'h0, avs_waitrequest, irq, power_event_output, rx_normal_enable});
    rd_chk("control reset", 8'h00, 32'h0);
    for (int i = 0; i < 4; i++)
      for (int s = 0; s < 4; s++)
      begin
        r = rnd();
        wr(8'((i + 1) * 16 + s * 4), r);
        rd_chk("filter field", 8'((i + 1) * 16 + s * 4), r & fm[s]);
      end
    wr(8'h80, rnd());
    rd_chk("unmapped", 8'h80, 32'h0);
    wr(8'h00, 32'hFFFF_FFFF);
    rd_chk("control rw", 8'h00, 32'h0000_0013);
    for (int i = 0; i < 4; i++)
    begin
      f_cmd[i] = 4'h0;
      wr(8'((i + 1) * 16 + 4), 32'h0);
    end
    build(station_addr, 16);
    run("own", 5'h01, 1'b0, 1'b1, 4'hC);
    build(48'hFFFF_FFFF_FFFF, 16);
    run("broadcast", 5'h11, 1'b0, 1'b1, 4'hC);
    build(station_addr ^ 48'h0000_0000_0F01, 16);
    run("multicast", 5'h01, 1'b0, 1'b1, 4'hC);
    build(station_addr, 16);
    run("bad fcs", 5'h01, 1'b0, 1'b0, 4'hC);
    build(station_addr, 15);
    run("short run", 5'h01, 1'b0, 1'b1, 4'hC);
    build(station_addr ^ 48'h0000_0000_0F00, 16);
    run("other unicast", 5'h01, 1'b0, 1'b1, 4'hC);
    build(station_addr, 16);
    run("not enabled", 5'h00, 1'b0, 1'b1, 4'hC);
    build(station_addr, 16);
    run("light sleep", 5'h00, 1'b1, 1'b1, 4'hC);
    build(station_addr, 16);
    run("masked", 5'h01, 1'b0, 1'b1, 4'h0);
    for (int i = 0; i < 4; i++)
    begin
      for (int v = 0; v < 4; v++)
      begin
        build(i[0] ? 48'hFFFF_FFFF_FFFF : station_addr, 0);
        f_off[i] = 8'(12 + rnd() % 20);
        f_mask[i] = 31'(rnd());
        f_cmd[i] = {i[0] ^ (v == 3), 2'b00, v != 2};
        f_crc[i] = crc_of(i) ^ {15'h0, v == 1};
        prog(i);
        run("filter", {3'b000, i != 3, 1'b0}, i == 3, 1'b1, 4'hC);
      end
      f_cmd[i] = 4'h0;
      prog(i);
    end
    give_verdict();
  end

  initial
  begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("[FAIL] watchdog expected finish seen timeout");
    give_verdict();
  end
endmodule : wfpd_tb_top
